// [common/host_fifo_regs.svh]
// Address map, field positions, sizes and reset values of the FIFO port
`ifndef HOST_FIFO_REGS_SVH
`define HOST_FIFO_REGS_SVH

`define HF_ADDR_W        14
`define HF_WIN_TOP       2'b00
`define HF_TAGS_TOP      3'b100
`define HF_W_FILTER      12'h400
`define HF_W_WCOUNT      12'h401
`define HF_W_FREE        12'h402
`define HF_W_IRQEN       12'h403
`define HF_W_IRQFLAG     12'h404
`define HF_W_XFER        12'h405

`define HF_OUT_DEPTH     5'd16
`define HF_OUT_AW        4
`define HF_IN_DEPTH      6'd32
`define HF_IN_AW         5

`define HF_FILTER_RST    8'h00
`define HF_IRQ_W         5
`define HF_IRQ_RST       5'h00
`define HF_IRQ_DMA       0
`define HF_IRQ_SYNC      1
`define HF_IRQ_EXT       2
`define HF_IRQ_ERR       3
`define HF_IRQ_RETRACE   4

`define HF_MODE_HOLD     2'h0
`define HF_MODE_INCR     2'h1
`define HF_MODE_INDEX    2'h2
`define HF_SYNC_MARK_BIT 31
`define HF_RESP_OKAY     2'b00
`define HF_RESP_SLVERR   2'b10

`endif

// [common/host_fifo_pkg.sv]
// Types shared by the FIFO port and its bench
package host_fifo_pkg;
  typedef enum logic [1:0] {
    cat_depth,
    cat_stencil,
    cat_color,
    cat_sync
  } category_e;

  typedef enum logic {
    raw_desc,
    raw_data
  } raw_state_e;

  typedef struct packed {
    logic [8:0]  tag;
    logic [31:0] data;
  } in_entry_s;

  typedef struct packed {
    logic        mark;
    logic [31:0] word;
  } out_entry_s;

  typedef struct packed {
    category_e   cat;
    logic [8:0]  tag;
    logic [31:0] data;
  } out_item_s;
endpackage

// [hdl/host_fifo_port.sv]
// Host FIFO port: output queue, raw and tagged input path, events
//
// Notes on behaviour
// - Output queue entries are 32 bits, holding either a tag or data.
// - Input queue entries pair a 9-bit tag with a 32-bit data word.
// - Filter control holds a 2-bit field per output category.
// - Field bit 0x1 enables tag output, bit 0x2 enables data output.
// - With both enabled, the tag enters the output queue before data.
// - A full output queue stalls the producer; nothing is dropped.
// - Occupancy is readable; host must not pop an empty queue.
// - A 1K-word window; any word read pops the output queue.
// - Any write into the window feeds the raw input path.
// - Writes to a register address pair its tag with the data.
// - Raw path takes a tag description, then data, in buffer formats.
// - A tag description uses no input queue entry.
// - Sync marker enters output queue; interrupt when it reaches head.
// - Sync interrupt also needs the sync data word's top bit set.
// - External board request is an interrupt source.
// - Error interrupt on write into a full input queue.
// - Retrace interrupt at the start of vertical blanking.
// - Each source has an enable bit and a status flag.
// - Writing one to a flag bit clears it.
`timescale 1ns/1ps
`default_nettype none
`include "host_fifo_regs.svh"

module host_fifo_port (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // AXI4-Lite write channels
  input  wire logic [`HF_ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [`HF_ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Internal producer of output items
  input  wire logic                        prod_valid,
  input  wire host_fifo_pkg::out_item_s    prod_item,
  output logic                             prod_ready,
  // Tag/data pairs towards the pipeline
  output logic                             pipe_valid,
  output host_fifo_pkg::in_entry_s         pipe_entry,
  input  wire logic                        pipe_ready,
  // Event sources
  input  wire logic [31:0]                 transfer_count_in,
  input  wire logic                        ext_irq_req,
  input  wire logic                        vblank_in,
  output logic                             irq
);

  // Write channel capture
  logic [`HF_ADDR_W-1:0] aw_addr;
  logic [31:0]           w_data;
  logic                  aw_full;
  logic                  w_full;
  logic                  bus_up;
  // Acts only once both halves are really captured, never out of reset
  wire write_fire = aw_full && w_full;
  wire [11:0] w_word    = aw_addr[`HF_ADDR_W-1:2];
  wire        w_win     = aw_addr[13:12] == `HF_WIN_TOP;
  wire        w_tagreg  = aw_addr[13:11] == `HF_TAGS_TOP;
  wire        w_filter  = w_word == `HF_W_FILTER;
  wire        w_irqen   = w_word == `HF_W_IRQEN;
  wire        w_irqflag = w_word == `HF_W_IRQFLAG;
  wire        w_ro      = w_word == `HF_W_WCOUNT || w_word == `HF_W_FREE ||
                          w_word == `HF_W_XFER;
  wire        w_mapped  = w_win || w_tagreg || w_filter || w_irqen ||
                          w_irqflag || w_ro;

  // Read channel decode
  wire        ar_fire  = s_axi_arvalid && s_axi_arready;
  wire [11:0] r_word   = s_axi_araddr[`HF_ADDR_W-1:2];
  wire        r_win    = s_axi_araddr[13:12] == `HF_WIN_TOP;
  wire        r_tagreg = s_axi_araddr[13:11] == `HF_TAGS_TOP;

  // Control and status state
  logic [7:0]              filter;
  logic [`HF_IRQ_W-1:0]    irq_en;
  logic [`HF_IRQ_W-1:0]    irq_flags;
  logic [31:0]             xfer_q;
  logic                    ext_q;
  logic                    vblank_q;

  // Output queue
  host_fifo_pkg::out_entry_s out_mem [0:`HF_OUT_DEPTH-1];
  logic [`HF_OUT_AW-1:0]     out_wr;
  logic [`HF_OUT_AW-1:0]     out_rd;
  logic [4:0]                out_count;
  logic                      head_seen;

  // Producer hold stage
  logic       pend_tag;
  logic       pend_data;
  logic [8:0] hold_tag;
  logic [31:0] hold_data;
  logic       hold_mark;
  logic       next_pend_tag;
  logic       next_pend_data;

  // Per-category enables from the filter fields
  logic [3:0] cat_tag_en;
  logic [3:0] cat_data_en;
  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_cat
      assign cat_tag_en[c]  = filter[2*c];
      assign cat_data_en[c] = filter[2*c+1];
    end
  endgenerate

  wire prod_take = prod_valid && prod_ready;
  wire out_full  = out_count == `HF_OUT_DEPTH;
  wire out_empty = out_count == 5'd0;
  // Stall while full rather than drop the pending word
  wire push_out  = (pend_tag || pend_data) && !out_full;
  wire pop_out   = ar_fire && r_win && !out_empty;
  wire [31:0] push_word = pend_tag ? {23'h000000, hold_tag}
                                   : hold_data;
  // Marker goes on the last word the item emits
  wire push_mark = hold_mark && (!pend_tag || !pend_data);
  wire [1:0] cat_idx = prod_item.cat;
  wire take_mark = prod_item.cat == host_fifo_pkg::cat_sync &&
                   prod_item.data[`HF_SYNC_MARK_BIT];

  always_comb begin
    next_pend_tag  = pend_tag;
    next_pend_data = pend_data;
    if (push_out) begin
      if (pend_tag) begin
        next_pend_tag = 1'b0;
      end else begin
        next_pend_data = 1'b0;
      end
    end
    if (prod_take) begin
      next_pend_tag  = cat_tag_en[cat_idx];
      next_pend_data = cat_data_en[cat_idx];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_tag   <= 1'b0;
      pend_data  <= 1'b0;
      hold_tag   <= 9'h000;
      hold_data  <= 32'h00000000;
      hold_mark  <= 1'b0;
      prod_ready <= 1'b0;
    end else begin
      pend_tag   <= next_pend_tag;
      pend_data  <= next_pend_data;
      prod_ready <= !(next_pend_tag || next_pend_data);
      if (prod_take) begin
        hold_tag  <= prod_item.tag;
        hold_data <= prod_item.data;
        hold_mark <= take_mark;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push_out) begin
      out_mem[out_wr] <= '{mark: push_mark, word: push_word};
    end
  end

  wire head_mark = !out_empty && out_mem[out_rd].mark;
  wire sync_event = head_mark && !head_seen;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_wr    <= '0;
      out_rd    <= '0;
      out_count <= 5'd0;
      head_seen <= 1'b0;
    end else begin
      if (push_out) begin
        out_wr <= out_wr + 1'b1;
      end
      if (pop_out) begin
        out_rd <= out_rd + 1'b1;
      end
      out_count <= out_count + {4'h0, push_out} - {4'h0, pop_out};
      head_seen <= head_mark && !pop_out;
    end
  end

  // Input queue and raw decoder
  host_fifo_pkg::in_entry_s in_mem [0:`HF_IN_DEPTH-1];
  logic [`HF_IN_AW-1:0]     in_wr;
  logic [`HF_IN_AW-1:0]     in_rd;
  logic [5:0]               in_count;
  host_fifo_pkg::raw_state_e raw_state;
  logic [1:0]               raw_mode;
  logic [8:0]               raw_tag;
  logic [15:0]              raw_left;
  logic [15:0]              raw_mask;

  function automatic logic [3:0] low_index(input logic [15:0] m);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i = i - 1) begin
      if (m[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  wire raw_is_data = raw_state == host_fifo_pkg::raw_data;
  wire raw_wr   = write_fire && w_win;
  wire raw_desc_wr = raw_wr && !raw_is_data;
  wire raw_data_wr = raw_wr && raw_is_data;
  wire [1:0] desc_mode = w_data[15:14];
  wire desc_bad = raw_desc_wr && desc_mode != `HF_MODE_HOLD &&
                  desc_mode != `HF_MODE_INCR && desc_mode != `HF_MODE_INDEX;
  wire [8:0] raw_cur_tag = raw_mode == `HF_MODE_INDEX ?
               {raw_tag[8:4], low_index(raw_mask)} : raw_tag;
  wire [15:0] mask_rest = raw_mask & (raw_mask - 16'h0001);
  wire in_want  = raw_data_wr || (write_fire && w_tagreg);
  wire in_full  = in_count == `HF_IN_DEPTH;
  wire in_push  = in_want && !in_full;
  wire in_err   = in_want && in_full;
  wire [8:0] in_tag = w_tagreg ? aw_addr[10:2] : raw_cur_tag;
  wire in_pop   = !(in_count == 6'd0) && (!pipe_valid || pipe_ready);

  always_ff @(posedge ref_clk) begin
    if (in_push) begin
      in_mem[in_wr] <= '{tag: in_tag, data: w_data};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      in_wr      <= '0;
      in_rd      <= '0;
      in_count   <= 6'd0;
      pipe_valid <= 1'b0;
      pipe_entry <= '0;
    end else begin
      if (in_push) begin
        in_wr <= in_wr + 1'b1;
      end
      if (in_pop) begin
        in_rd      <= in_rd + 1'b1;
        pipe_entry <= in_mem[in_rd];
      end
      if (in_pop) begin
        pipe_valid <= 1'b1;
      end else if (pipe_ready) begin
        pipe_valid <= 1'b0;
      end
      in_count <= in_count + {5'h00, in_push} - {5'h00, in_pop};
    end
  end

  // A dropped word still advances the decoder to keep the stream aligned
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      raw_state <= host_fifo_pkg::raw_desc;
      raw_mode  <= `HF_MODE_HOLD;
      raw_tag   <= 9'h000;
      raw_left  <= 16'h0000;
      raw_mask  <= 16'h0000;
    end else if (raw_desc_wr && !desc_bad) begin
      raw_mode <= desc_mode;
      raw_tag  <= w_data[8:0];
      raw_left <= w_data[31:16];
      raw_mask <= w_data[31:16];
      if (desc_mode != `HF_MODE_INDEX || w_data[31:16] != 16'h0000) begin
        raw_state <= host_fifo_pkg::raw_data;
      end
    end else if (raw_data_wr) begin
      unique case (raw_mode)
        `HF_MODE_INDEX: begin
          raw_mask <= mask_rest;
          if (mask_rest == 16'h0000) begin
            raw_state <= host_fifo_pkg::raw_desc;
          end
        end
        default: begin
          if (raw_mode == `HF_MODE_INCR) begin
            raw_tag <= raw_tag + 9'h001;
          end
          raw_left <= raw_left - 16'h0001;
          if (raw_left == 16'h0000) begin
            raw_state <= host_fifo_pkg::raw_desc;
          end
        end
      endcase
    end
  end

  // Interrupt sources, enables and flags
  wire [`HF_IRQ_W-1:0] irq_src;
  assign irq_src[`HF_IRQ_DMA]     = xfer_q != 32'h00000000 &&
                                    transfer_count_in == 32'h00000000;
  assign irq_src[`HF_IRQ_SYNC]    = sync_event;
  assign irq_src[`HF_IRQ_EXT]     = ext_irq_req && !ext_q;
  assign irq_src[`HF_IRQ_ERR]     = in_err || desc_bad;
  assign irq_src[`HF_IRQ_RETRACE] = vblank_in && !vblank_q;
  wire [`HF_IRQ_W-1:0] irq_clr = (write_fire && w_irqflag) ?
                                 w_data[`HF_IRQ_W-1:0] : `HF_IRQ_RST;
  // Set wins over a clear in the same cycle
  wire [`HF_IRQ_W-1:0] next_flags = (irq_flags & ~irq_clr) |
                                    (irq_src & irq_en);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      filter    <= `HF_FILTER_RST;
      irq_en    <= `HF_IRQ_RST;
      irq_flags <= `HF_IRQ_RST;
      irq       <= 1'b0;
      xfer_q    <= 32'h00000000;
      ext_q     <= 1'b0;
      vblank_q  <= 1'b0;
    end else begin
      if (write_fire && w_filter) begin
        filter <= w_data[7:0];
      end
      if (write_fire && w_irqen) begin
        irq_en <= w_data[`HF_IRQ_W-1:0];
      end
      irq_flags <= next_flags;
      irq       <= |(next_flags & irq_en);
      xfer_q    <= transfer_count_in;
      ext_q     <= ext_irq_req;
      vblank_q  <= vblank_in;
    end
  end

  // Read data selection
  wire [31:0] win_data = out_empty ? 32'h00000000 : out_mem[out_rd].word;
  wire [5:0]  in_free  = `HF_IN_DEPTH - in_count;
  logic [31:0] next_rdata;
  logic        r_ok;
  always_comb begin
    next_rdata = 32'h00000000;
    r_ok       = 1'b1;
    if (r_win) begin
      next_rdata = win_data;
    end else if (r_tagreg) begin
      next_rdata = 32'h00000000;
    end else if (r_word == `HF_W_FILTER) begin
      next_rdata = {24'h000000, filter};
    end else if (r_word == `HF_W_WCOUNT) begin
      next_rdata = {27'h0000000, out_count};
    end else if (r_word == `HF_W_FREE) begin
      next_rdata = {26'h0000000, in_free};
    end else if (r_word == `HF_W_IRQEN) begin
      next_rdata = {27'h0000000, irq_en};
    end else if (r_word == `HF_W_IRQFLAG) begin
      next_rdata = {27'h0000000, irq_flags};
    end else if (r_word == `HF_W_XFER) begin
      next_rdata = xfer_q;
    end else begin
      r_ok = 1'b0;
    end
  end

  // AXI4-Lite handshakes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `HF_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `HF_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_addr       <= '0;
      w_data        <= 32'h00000000;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      bus_up        <= 1'b0;
    end else begin
      // Readies open at the first edge after reset release
      bus_up <= 1'b1;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
        aw_full       <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_full       <= 1'b1;
      end
      if (write_fire) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_mapped ? `HF_RESP_OKAY : `HF_RESP_SLVERR;
      end else if (!bus_up || (s_axi_bvalid && s_axi_bready)) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= r_ok ? `HF_RESP_OKAY : `HF_RESP_SLVERR;
      end else if (!bus_up || (s_axi_rvalid && s_axi_rready)) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [sim/host_fifo_port_props.sv]
// Bus and stream handshake checker for the host FIFO port
`timescale 1ns/1ps
`default_nettype none
module host_fifo_port_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pair stream
  input wire logic        pipe_valid,
  input wire host_fifo_pkg::in_entry_s pipe_entry,
  input wire logic        pipe_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_write_blocked: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_write_reopen: assert property (s_axi_bvalid && s_axi_bready |=>
    s_axi_awready && s_axi_wready) else $error("write not reopened");
  a_read_answer: assert property (rd_taken |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_reopen: assert property (s_axi_rvalid && s_axi_rready |=>
    s_axi_arready && !s_axi_rvalid) else $error("read not closed");
  a_pair_held: assert property (pipe_valid && !pipe_ready |=>
    pipe_valid && $stable(pipe_entry)) else $error("pair dropped");
endmodule
bind host_fifo_port host_fifo_port_props host_fifo_port_props_inst (
  .ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pipe_valid,
  .pipe_entry, .pipe_ready);
`default_nettype wire

// [sim/pipe_sink.sv]
// Pipeline consumer model that collects tag/data pairs
`timescale 1ns/1ps
`default_nettype none
module pipe_sink (
  // Clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  // Pair stream
  input wire logic                     pipe_valid,
  input wire host_fifo_pkg::in_entry_s pipe_entry,
  output logic                         pipe_ready,
  // Bench control: stall holds pairs back in the input queue
  input wire logic                     stall
);
  host_fifo_pkg::in_entry_s got[$];
  always @(posedge ref_clk) begin
    pipe_ready <= rst_n && !stall;
    if (rst_n && pipe_valid && pipe_ready) begin
      got.push_back(pipe_entry);
    end
  end
endmodule
`default_nettype wire

// [sim/host_fifo_port_tb.sv]
// Self-checking bench for the host FIFO port
`timescale 1ns/1ps
`default_nettype none
module host_fifo_port_tb;
  logic        ref_clk = 1'h0, rst_n = 1'h0;
  logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, transfer_count_in = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, prod_valid = 1'h0;
  logic        ext_irq_req = 1'h0, vblank_in = 1'h0, stall = 1'h0;
  host_fifo_pkg::out_item_s prod_item = '0;
  host_fifo_pkg::in_entry_s pipe_entry;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, prod_ready, pipe_valid, pipe_ready, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int          fail_count = 0, n_tests = 0, cycles = 0;

  always #5 ref_clk = ~ref_clk;
  host_fifo_port host_fifo_port_inst (.ref_clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .prod_valid, .prod_item, .prod_ready, .pipe_valid,
    .pipe_entry, .pipe_ready, .transfer_count_in, .ext_irq_req, .vblank_in,
    .irq);
  pipe_sink pipe_sink_inst (.ref_clk, .rst_n, .pipe_valid, .pipe_entry,
    .pipe_ready, .stall);

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // A hang is cut short well beyond the several hundred cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [40:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge ref_clk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (!s_axi_bvalid) @(posedge ref_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic wrq(input logic [13:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask
  task automatic rd(input logic [13:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rdc(input string what, input logic [13:0] a,
                     input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(what, {r, d}, {2'h0, exp});
  endtask
  // Polls a status word until it reaches the wanted value, bounded
  task automatic poll(input logic [13:0] a, input logic [31:0] n);
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 40; k++) begin
      rd(a, d, r);
      if (d === n) break;
    end
  endtask
  task automatic push(input host_fifo_pkg::category_e c, input logic [31:0] d,
                      input int n);
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      prod_item <= {c, 9'h1A5, d + i};
      prod_valid <= 1'h1;
      do @(posedge ref_clk); while (!prod_ready);
    end
    prod_valid <= 1'h0;
  endtask
  task automatic pulse(input logic vb);
    @(posedge ref_clk);
    if (vb) vblank_in <= 1'h1;
    else ext_irq_req <= 1'h1;
    repeat (3) @(posedge ref_clk);
    vblank_in <= 1'h0;
    ext_irq_req <= 1'h0;
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rdc("filter reset", 14'h1000, 32'h0);
    rdc("count reset", 14'h1004, 32'h0);
    rdc("free reset", 14'h1008, 32'h20);
    wr(14'h3000, 32'h1, r);
    chk("unmapped bresp", r, 2'h2);
    rd(14'h3000, d, r);
    chk("unmapped read", {r, d}, {2'h2, 32'h0});
  endtask
  task automatic t_filter;
    logic [31:0] n, base;
    for (int c = 0; c < 4; c++) begin
      for (int m = 0; m < 4; m++) begin
        base = 32'hC0DE0000 + 32'(c * 4 + m);
        n = 32'(m[0]) + 32'(m[1]);
        wrq(14'h1000, 32'(m << (2 * c)));
        push(host_fifo_pkg::category_e'(c), base, 1);
        poll(14'h1004, n);
        rdc("word count", 14'h1004, n);
        if (m[0]) rdc("tag word", 14'(16 * c + 4 * m), 32'h1A5);
        if (m[1]) rdc("data word", 14'h0FFC, base);
        rdc("drained count", 14'h1004, 32'h0);
      end
    end
  endtask
  task automatic t_stall;
    wrq(14'h1000, 32'h20);
    fork
      push(host_fifo_pkg::cat_color, 32'h50000000, 17);
    join_none
    poll(14'h1004, 32'h10);
    rdc("full count", 14'h1004, 32'h10);
    chk("producer held", prod_ready, 1'h0);
    for (int i = 0; i < 17; i++) begin
      rdc("stalled data", 14'(i * 240), 32'h50000000 + i);
    end
    rdc("empty count", 14'h1004, 32'h0);
    rdc("empty pop", 14'h0000, 32'h0);
  endtask
  task automatic t_raw;
    logic [8:0] tags[8] = '{9'h020, 9'h021, 9'h022, 9'h0F1, 9'h0F4, 9'h0F5,
                            9'h031, 9'h155};
    @(posedge ref_clk);
    stall <= 1'h1;
    rdc("free before raw", 14'h1008, 32'h20);
    wrq(14'h0000, 32'h00024020);
    rdc("free after desc", 14'h1008, 32'h20);
    for (int i = 0; i < 3; i++) wrq(14'(4 * i + 4), 32'hA0000000 + i);
    wrq(14'h0000, 32'h003280F0);
    for (int i = 3; i < 6; i++) wrq(14'h0000, 32'hA0000000 + i);
    wrq(14'h0800, 32'h00000031);
    wrq(14'h0800, 32'hA0000006);
    wrq(14'h2554, 32'hA0000007);
    @(posedge ref_clk);
    stall <= 1'h0;
    for (int k = 0; k < 200 && pipe_sink_inst.got.size() < 8; k++) begin
      @(posedge ref_clk);
    end
    chk("pair count", 41'(pipe_sink_inst.got.size()), 41'h8);
    for (int i = 0; i < 8; i++) begin
      chk("pair", pipe_sink_inst.got[i], {tags[i], 32'hA0000000 + i});
    end
  endtask
  task automatic t_irq;
    wrq(14'h100C, 32'h1F);
    wrq(14'h1000, 32'h40);
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: begin
          @(posedge ref_clk);
          transfer_count_in <= 32'h5;
          rdc("xfer count", 14'h1014, 32'h5);
          transfer_count_in <= 32'h0;
        end
        1: push(host_fifo_pkg::cat_sync, 32'h80000000, 1);
        2: pulse(1'h0);
        3: wrq(14'h0000, 32'h0000C000);
        default: pulse(1'h1);
      endcase
      poll(14'h1010, 32'(1 << i));
      rdc("flag set", 14'h1010, 32'(1 << i));
      chk("irq raised", irq, 1'h1);
      if (i == 1) rdc("sync tag", 14'h0000, 32'h1A5);
      wrq(14'h1010, 32'(1 << i));
      rdc("flag cleared", 14'h1010, 32'h0);
      chk("irq dropped", irq, 1'h0);
    end
    push(host_fifo_pkg::cat_sync, 32'h00000001, 1);
    poll(14'h1004, 32'h1);
    rdc("plain sync tag", 14'h0000, 32'h1A5);
    rdc("no sync flag", 14'h1010, 32'h0);
    wrq(14'h100C, 32'h0);
    pulse(1'h0);
    rdc("masked flag", 14'h1010, 32'h0);
    chk("masked irq", irq, 1'h0);
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_filter();
    t_stall();
    t_raw();
    t_irq();
    give_verdict();
  end
endmodule
`default_nettype wire
